// *** design/can_sfr_pkg.sv ***
// shared constants for the cpu to can special-function-register port
package can_sfr_pkg;

   // ------------------------------------------------------------
   // sfr byte addresses
   // ------------------------------------------------------------
   localparam logic [7:0] STATUS_AND_DMA_RAM_POINTER_ADDR   = 8'hD8;
   localparam logic [7:0] INTERRUPT_READ_COMMAND_WRITE_ADDR = 8'hD9;
   localparam logic [7:0] INDIRECT_DATA_PORT_ADDR           = 8'hDA;
   localparam logic [7:0] INDIRECT_INDEX_SELECT_ADDR        = 8'hDB;

   // ------------------------------------------------------------
   // bit addresses of the bit-addressable status / pointer register
   // ------------------------------------------------------------
   localparam logic [7:0] STATUS_BIT_ADDR_LO = 8'hD8;
   localparam logic [7:0] STATUS_BIT_ADDR_HI = 8'hDF;

   // ------------------------------------------------------------
   // index select fields
   // ------------------------------------------------------------
   localparam int         DMA_GO_BIT        = 7;
   localparam int         RESERVED_IDX_BIT  = 6;
   localparam int         AUTO_INDEX_BUMP   = 5;
   localparam int         INDEX_SELECT_MSB  = 4;
   localparam int         INDEX_W           = 5;
   localparam int         BUMP_W            = 6;
   localparam logic [7:0] INDEX_RESET_VALUE = 8'h64;

   // ------------------------------------------------------------
   // interrupt read fields
   // ------------------------------------------------------------
   localparam int         IRQ_W             = 5;
   localparam logic [2:0] IRQ_RESERVED_ONES = 3'h7;
   localparam int         WAKE_IRQ_FLAG     = 4;
   localparam int         OVERRUN_IRQ_FLAG  = 3;
   localparam int         ERROR_IRQ_FLAG    = 2;
   localparam int         TX_IRQ_FLAG       = 1;
   localparam int         RX_IRQ_FLAG       = 0;

   // ------------------------------------------------------------
   // command write fields
   // ------------------------------------------------------------
   localparam int         INPUT0_ACTIVE         = 7;
   localparam int         INPUT1_ACTIVE         = 6;
   localparam int         WAKE_MODE             = 5;
   localparam int         SLEEP_CMD             = 4;
   localparam int         CLEAR_OVERRUN_CMD     = 3;
   localparam int         RELEASE_RX_BUFFER_CMD = 2;
   localparam int         ABORT_TX_CMD          = 1;
   localparam int         TX_REQUEST_CMD        = 0;

   // ------------------------------------------------------------
   // status read fields
   // ------------------------------------------------------------
   localparam int         BUS_STATE_FLAG       = 7;
   localparam int         ERROR_STATE_FLAG     = 6;
   localparam int         TX_STATE_FLAG        = 5;
   localparam int         RX_STATE_FLAG        = 4;
   localparam int         TX_COMPLETE_FLAG     = 3;
   localparam int         TX_BUFFER_FREE_FLAG  = 2;
   localparam int         DATA_OVERRUN_FLAG    = 1;
   localparam int         RX_BUFFER_FULL_FLAG  = 0;

   // ------------------------------------------------------------
   // reset values
   // ------------------------------------------------------------
   localparam logic [7:0] RAM_POINTER_RESET = 8'h00;
   localparam logic [7:0] BYTE_ZERO         = 8'h00;

endpackage

// *** design/index_select_reg.sv ***
// index select register with auto bump and dma go bit
`timescale 1ns/1ps
module index_select_reg (
   // clock and reset
   input  wire logic       ref_clk_i,
   input  wire logic       rst_n_i,
   // cpu write
   input  wire logic       wr_i,
   input  wire logic [7:0] wdata_i,
   // hardware events
   input  wire logic       bump_i,
   input  wire logic       dma_clear_i,
   input  wire logic       dma_block_i,
   // state
   output logic      [7:0] index_o,
   output logic            dma_start_o
);

   logic [7:0] index_reg;
   logic [7:0] index_next;
   logic       start_reg;
   logic       start_next;
   logic [5:0] bumped;

   // ------------------------------------------------------------
   // next value
   // ------------------------------------------------------------
   // carry out of the index bits lands in the bump bit, so passing
   // the top index turns auto bump off by itself
   always_comb begin
      bumped     = index_reg[5:0] + 6'h01;
      index_next = index_reg;
      start_next = 1'b0;
      if (wr_i) begin
         index_next = wdata_i;
         // cpu write selects, and a set go bit launches dma unless a reset request blocks it
         if (wdata_i[can_sfr_pkg::DMA_GO_BIT]) begin
            if (dma_block_i) begin
               index_next[can_sfr_pkg::DMA_GO_BIT] = 1'b0;
            end else begin
               start_next = 1'b1;
            end
         end
      end else begin
         if (bump_i) begin
            index_next[5:0] = bumped;
         end
         if (dma_clear_i) begin
            index_next[can_sfr_pkg::DMA_GO_BIT] = 1'b0;
         end
      end
   end

   // ------------------------------------------------------------
   // storage
   // ------------------------------------------------------------
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         index_reg <= can_sfr_pkg::INDEX_RESET_VALUE;
      end else begin
         index_reg <= index_next;
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         start_reg <= 1'b0;
      end else begin
         start_reg <= start_next;
      end
   end

   assign index_o     = index_reg;
   assign dma_start_o = start_reg;

endmodule // index_select_reg

// *** design/cpu_can_sfr_port.sv ***
// cpu side special-function-register port to the can controller and dma
`timescale 1ns/1ps
module cpu_can_sfr_port (
   // clock and reset
   input  wire logic       ref_clk_i,
   input  wire logic       reset_n_i,
   // cpu byte access
   input  wire logic [7:0] sfr_addr_i,
   input  wire logic       sfr_rd_i,
   input  wire logic       sfr_wr_i,
   input  wire logic [7:0] sfr_wdata_i,
   output logic      [7:0] sfr_rdata_o,
   output logic            sfr_rvalid_o,
   // cpu bit access
   input  wire logic [7:0] bit_addr_i,
   input  wire logic       bit_rd_i,
   input  wire logic       bit_wr_i,
   input  wire logic       bit_wdata_i,
   output logic            bit_rdata_o,
   output logic            bit_rvalid_o,
   // controller internal register file
   output logic      [4:0] can_reg_addr_o,
   output logic            can_reg_rd_o,
   output logic            can_reg_wr_o,
   output logic      [7:0] can_reg_wdata_o,
   input  wire logic [7:0] can_reg_rdata_i,
   // controller interrupt, command and status
   input  wire logic [4:0] can_irq_i,
   input  wire logic [7:0] can_status_i,
   output logic            can_cmd_wr_o,
   output logic      [7:0] can_cmd_o,
   input  wire logic       can_reset_request_i,
   // dma logic
   output logic            dma_start_o,
   output logic      [7:0] dma_ram_addr_o,
   output logic      [4:0] dma_buf_addr_o,
   output logic            dma_busy_o,
   input  wire logic       dma_done_i,
   input  wire logic       dma_ok_i,
   // index state for the core
   output logic            auto_index_bump_o
);

   // ------------------------------------------------------------
   // reset release
   // ------------------------------------------------------------
   logic rst_meta_reg;
   logic rst_n_reg;

   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         rst_meta_reg <= 1'b0;
         rst_n_reg    <= 1'b0;
      end else begin
         rst_meta_reg <= 1'b1;
         rst_n_reg    <= rst_meta_reg;
      end
   end

   // ------------------------------------------------------------
   // address decode
   // ------------------------------------------------------------
   function automatic logic hit(input logic [7:0] a, input logic [7:0] ref_a);
      hit = (a == ref_a);
   endfunction

   logic sel_sta;
   logic sel_con;
   logic sel_dat;
   logic sel_idx;
   logic bit_sel;
   logic [2:0] bit_pos;

   assign sel_sta = hit(sfr_addr_i, can_sfr_pkg::STATUS_AND_DMA_RAM_POINTER_ADDR);
   assign sel_con = hit(sfr_addr_i, can_sfr_pkg::INTERRUPT_READ_COMMAND_WRITE_ADDR);
   assign sel_dat = hit(sfr_addr_i, can_sfr_pkg::INDIRECT_DATA_PORT_ADDR);
   assign sel_idx = hit(sfr_addr_i, can_sfr_pkg::INDIRECT_INDEX_SELECT_ADDR);
   assign bit_sel = (bit_addr_i >= can_sfr_pkg::STATUS_BIT_ADDR_LO)
                 && (bit_addr_i <= can_sfr_pkg::STATUS_BIT_ADDR_HI);
   assign bit_pos = bit_addr_i[2:0];

   // ------------------------------------------------------------
   // index select register
   // ------------------------------------------------------------
   logic [7:0] index_val;
   logic       start_pulse;
   logic       dat_access;
   logic       idx_wr;
   logic       dma_clear;
   logic       dma_busy_reg;

   // accesses while dma runs are forbidden to software; the port
   // drops them so the running transfer keeps a stable index
   assign idx_wr     = sfr_wr_i && sel_idx && !dma_busy_reg;
   assign dat_access = (sfr_rd_i || sfr_wr_i) && sel_dat && !dma_busy_reg;
   assign dma_clear  = dma_busy_reg && dma_done_i && dma_ok_i;

   index_select_reg index_select_reg_i (
      .ref_clk_i   (ref_clk_i),
      .rst_n_i     (rst_n_reg),
      .wr_i        (idx_wr),
      .wdata_i     (sfr_wdata_i),
      .bump_i      (dat_access && index_val[can_sfr_pkg::AUTO_INDEX_BUMP]),
      .dma_clear_i (dma_clear),
      .dma_block_i (can_reset_request_i),
      .index_o     (index_val),
      .dma_start_o (start_pulse)
   );

   // ------------------------------------------------------------
   // dma busy tracking
   // ------------------------------------------------------------
   // a failed transfer ends busy but leaves the go bit standing
   always_ff @(posedge ref_clk_i or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         dma_busy_reg <= 1'b0;
      end else if (start_pulse) begin
         dma_busy_reg <= 1'b1;
      end else if (dma_done_i || can_reset_request_i) begin
         dma_busy_reg <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // dma ram start pointer
   // ------------------------------------------------------------
   logic [7:0] ram_ptr_reg;

   always_ff @(posedge ref_clk_i or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         ram_ptr_reg <= can_sfr_pkg::RAM_POINTER_RESET;
      end else if (dma_busy_reg) begin
         ram_ptr_reg <= ram_ptr_reg;
      end else if (sfr_wr_i && sel_sta) begin
         ram_ptr_reg <= sfr_wdata_i;
      end else if (bit_wr_i && bit_sel) begin
         ram_ptr_reg[bit_pos] <= bit_wdata_i;
      end
   end

   // ------------------------------------------------------------
   // byte read data
   // ------------------------------------------------------------
   logic [7:0] rd_mux;

   always_comb begin
      rd_mux = can_sfr_pkg::BYTE_ZERO;
      if (sel_idx) begin
         rd_mux = index_val;
      end else if (sel_dat) begin
         rd_mux = can_reg_rdata_i;
      end else if (sel_con) begin
         rd_mux = {can_sfr_pkg::IRQ_RESERVED_ONES, can_irq_i};
      end else if (sel_sta) begin
         rd_mux = can_status_i;
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         sfr_rvalid_o <= 1'b0;
      end else begin
         sfr_rvalid_o <= sfr_rd_i;
      end
   end

   // read data holds until the next read
   always_ff @(posedge ref_clk_i or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         sfr_rdata_o <= can_sfr_pkg::BYTE_ZERO;
      end else if (sfr_rd_i) begin
         sfr_rdata_o <= rd_mux;
      end
   end

   // ------------------------------------------------------------
   // bit read data
   // ------------------------------------------------------------
   always_ff @(posedge ref_clk_i or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         bit_rvalid_o <= 1'b0;
      end else begin
         bit_rvalid_o <= bit_rd_i;
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         bit_rdata_o <= 1'b0;
      end else if (bit_rd_i) begin
         bit_rdata_o <= bit_sel && can_status_i[bit_pos];
      end
   end

   // ------------------------------------------------------------
   // indirect register file strobes
   // ------------------------------------------------------------
   // strobes lag the cpu access by one cycle; the address, one cycle
   // behind the index, shows the register that the access used, so
   // back-to-back writes each land on their own register
   // limitation: a data port read needs one quiet cycle after an
   // index change or a data port access
   logic [4:0] acc_addr;

   assign acc_addr = index_val[can_sfr_pkg::INDEX_SELECT_MSB:0];

   always_ff @(posedge ref_clk_i or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         can_reg_rd_o <= 1'b0;
         can_reg_wr_o <= 1'b0;
      end else begin
         can_reg_rd_o <= dat_access && sfr_rd_i;
         can_reg_wr_o <= dat_access && sfr_wr_i;
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         can_reg_wdata_o <= can_sfr_pkg::BYTE_ZERO;
      end else if (dat_access && sfr_wr_i) begin
         can_reg_wdata_o <= sfr_wdata_i;
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         can_reg_addr_o <= can_sfr_pkg::INDEX_RESET_VALUE[4:0];
      end else begin
         can_reg_addr_o <= acc_addr;
      end
   end

   // ------------------------------------------------------------
   // command register write
   // ------------------------------------------------------------
   logic cmd_wr;

   assign cmd_wr = sfr_wr_i && sel_con && !dma_busy_reg;

   always_ff @(posedge ref_clk_i or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         can_cmd_wr_o <= 1'b0;
      end else begin
         can_cmd_wr_o <= cmd_wr;
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         can_cmd_o <= can_sfr_pkg::BYTE_ZERO;
      end else if (cmd_wr) begin
         can_cmd_o <= sfr_wdata_i;
      end
   end

   // ------------------------------------------------------------
   // dma outputs
   // ------------------------------------------------------------
   always_ff @(posedge ref_clk_i or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         dma_start_o <= 1'b0;
      end else begin
         dma_start_o <= start_pulse && !can_reset_request_i;
      end
   end

   // transfer addresses are captured once, at the launch
   always_ff @(posedge ref_clk_i or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         dma_ram_addr_o <= can_sfr_pkg::RAM_POINTER_RESET;
         dma_buf_addr_o <= can_sfr_pkg::INDEX_RESET_VALUE[4:0];
      end else if (start_pulse) begin
         dma_ram_addr_o <= ram_ptr_reg;
         dma_buf_addr_o <= acc_addr;
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         dma_busy_o <= 1'b0;
      end else begin
         dma_busy_o <= dma_busy_reg;
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         auto_index_bump_o <= 1'b0;
      end else begin
         auto_index_bump_o <= index_val[can_sfr_pkg::AUTO_INDEX_BUMP];
      end
   end

endmodule // cpu_can_sfr_port

// *** verif/can_sfr_port_chk.sv ***
// assertion checker for the cpu to can sfr port
`timescale 1ns/1ps
module can_sfr_port_chk (
   // clock and reset
   input wire logic       ref_clk_i,
   input wire logic       reset_n_i,
   // cpu byte access
   input wire logic [7:0] sfr_addr_i,
   input wire logic       sfr_rd_i,
   input wire logic       sfr_wr_i,
   input wire logic [7:0] sfr_wdata_i,
   input wire logic [7:0] sfr_rdata_o,
   input wire logic       sfr_rvalid_o,
   // controller side
   input wire logic [4:0] can_reg_addr_o,
   input wire logic       can_reg_rd_o,
   input wire logic       can_reg_wr_o,
   input wire logic [7:0] can_reg_wdata_o,
   input wire logic [7:0] can_reg_rdata_i,
   input wire logic [4:0] can_irq_i,
   input wire logic [7:0] can_status_i,
   input wire logic       can_cmd_wr_o,
   input wire logic [7:0] can_cmd_o,
   input wire logic       can_reset_request_i,
   // dma and index state
   input wire logic       dma_start_o,
   input wire logic [4:0] dma_buf_addr_o,
   input wire logic       dma_busy_o,
   input wire logic       auto_index_bump_o
);
   // accesses in the dma shadow are dropped, so the write, data port and launch checks judge only quiet cycles
   logic idle;
   assign idle = !dma_busy_o && !dma_start_o;

   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!reset_n_i);

   sequence s_rd(logic [7:0] a);
      sfr_rd_i && sfr_addr_i == a;
   endsequence
   sequence s_wr(logic [7:0] a);
      sfr_wr_i && sfr_addr_i == a && idle;
   endsequence
   sequence s_port_then_quiet;
      (sfr_rd_i || sfr_wr_i) && sfr_addr_i == can_sfr_pkg::INDIRECT_DATA_PORT_ADDR && idle ##1 !sfr_rd_i && !sfr_wr_i;
   endsequence
   sequence s_launch(logic rr);
      sfr_wr_i && sfr_addr_i == can_sfr_pkg::INDIRECT_INDEX_SELECT_ADDR && sfr_wdata_i[7] && idle
         && can_reset_request_i == rr;
   endsequence

   AST_IRQ_READ: assert property (s_rd(can_sfr_pkg::INTERRUPT_READ_COMMAND_WRITE_ADDR) |=> sfr_rvalid_o
      && sfr_rdata_o == {3'h7, $past(can_irq_i)}) else $error("interrupt read mismatch");
   AST_STATUS_READ: assert property (s_rd(can_sfr_pkg::STATUS_AND_DMA_RAM_POINTER_ADDR) |=> sfr_rvalid_o
      && sfr_rdata_o == $past(can_status_i)) else $error("status read mismatch");
   AST_CMD_WRITE: assert property (s_wr(can_sfr_pkg::INTERRUPT_READ_COMMAND_WRITE_ADDR) |=> can_cmd_wr_o
      && can_cmd_o == $past(sfr_wdata_i)) else $error("command write mismatch");
   AST_DATA_WRITE: assert property (s_wr(can_sfr_pkg::INDIRECT_DATA_PORT_ADDR) |=> can_reg_wr_o
      && can_reg_wdata_o == $past(sfr_wdata_i)) else $error("data port write mismatch");
   AST_DATA_READ: assert property (s_rd(can_sfr_pkg::INDIRECT_DATA_PORT_ADDR) ##0 idle |=> can_reg_rd_o
      && sfr_rvalid_o && sfr_rdata_o == $past(can_reg_rdata_i)) else $error("data port read mismatch");
   AST_STROBE_CAUSE: assert property (can_reg_wr_o || can_reg_rd_o |->
      $past(sfr_addr_i) == can_sfr_pkg::INDIRECT_DATA_PORT_ADDR && ($past(sfr_rd_i) || $past(sfr_wr_i)))
      else $error("register strobe without data port access");
   AST_CMD_CAUSE: assert property (can_cmd_wr_o |->
      $past(sfr_wr_i) && $past(sfr_addr_i) == can_sfr_pkg::INTERRUPT_READ_COMMAND_WRITE_ADDR)
      else $error("command strobe without command write");
   AST_DMA_START: assert property (s_launch(1'b0) |=> ##1 dma_start_o
      && dma_buf_addr_o == 5'($past(sfr_wdata_i, 2))) else $error("dma launch mismatch");
   AST_DMA_BLOCKED: assert property (s_launch(1'b1) |=> !dma_start_o [*2])
      else $error("dma launched under reset request");
   AST_BUMP: assert property (s_port_then_quiet |=> can_reg_addr_o ==
      5'($past(can_reg_addr_o, 2) + $past(auto_index_bump_o, 2))) else $error("index step mismatch");
endmodule // can_sfr_port_chk

bind cpu_can_sfr_port can_sfr_port_chk can_sfr_port_chk_i (.*);

// *** verif/can_core_model.sv ***
// behavioural controller core: register file, command capture, dma completion
`timescale 1ns/1ps
module can_core_model #(
   parameter int DONE_LAT = 6
) (
   // clock
   input  wire logic       ref_clk_i,
   // internal register file
   input  wire logic [4:0] reg_addr_i,
   input  wire logic       reg_wr_i,
   input  wire logic [7:0] reg_wdata_i,
   output logic      [7:0] reg_rdata_o,
   // command register
   input  wire logic       cmd_wr_i,
   input  wire logic [7:0] cmd_i,
   // dma engine
   input  wire logic       dma_start_i,
   input  wire logic [7:0] dma_ram_addr_i,
   input  wire logic [4:0] dma_buf_addr_i,
   input  wire logic       ok_mode_i,
   output logic            dma_done_o,
   output logic            dma_ok_o
);
   logic [7:0] mem [32];
   logic [7:0] last_cmd = 8'h00;
   logic [7:0] ram_seen = 8'h00;
   logic [4:0] buf_seen = 5'h00;
   int         starts   = 0;
   int         cnt      = 0;
   initial foreach (mem[i]) mem[i] = 8'h00;
   initial dma_done_o = 1'b0;
   assign reg_rdata_o = mem[reg_addr_i];
   // ok only means something beside done, so it lies otherwise
   assign dma_ok_o = dma_done_o ? ok_mode_i : !ok_mode_i;
   always @(posedge ref_clk_i) begin
      if (reg_wr_i) mem[reg_addr_i] <= reg_wdata_i;
      if (cmd_wr_i) last_cmd <= cmd_i;
      dma_done_o <= (cnt == 1);
      if (dma_start_i) begin
         cnt      <= DONE_LAT;
         starts   <= starts + 1;
         ram_seen <= dma_ram_addr_i;
         buf_seen <= dma_buf_addr_i;
      end else if (cnt > 0) begin
         cnt <= cnt - 1;
      end
   end
endmodule // can_core_model

// *** verif/cpu_can_sfr_port_tb.sv ***
// self-checking bench for the cpu to can sfr port
`timescale 1ns/1ps
module cpu_can_sfr_port_tb;
   typedef struct {logic [7:0] addr; logic [4:0] irq; logic [7:0] stat; logic [7:0] exp;} row_s;
   logic       ref_clk_i = 1'b0, reset_n_i = 1'b0, ok_mode = 1'b0, b;
   logic       sfr_rd_i = 1'b0, sfr_wr_i = 1'b0, bit_rd_i = 1'b0, bit_wr_i = 1'b0, bit_wdata_i = 1'b0;
   logic       can_reset_request_i = 1'b0;
   logic [7:0] sfr_addr_i = 8'h00, sfr_wdata_i = 8'h00, bit_addr_i = 8'h00, can_status_i = 8'h00, q;
   logic [4:0] can_irq_i = 5'h00;
   logic [7:0] sfr_rdata_o, can_reg_wdata_o, can_reg_rdata_i, can_cmd_o, dma_ram_addr_o;
   logic [4:0] can_reg_addr_o, dma_buf_addr_o;
   logic       sfr_rvalid_o, bit_rdata_o, bit_rvalid_o, can_reg_rd_o, can_reg_wr_o, can_cmd_wr_o;
   logic       dma_start_o, dma_busy_o, dma_done_i, dma_ok_i, auto_index_bump_o;
   int         mismatches = 0, num_checks = 0;
   row_s       rows [6] = '{'{8'hD9, 5'h00, 8'h00, 8'hE0}, '{8'hD9, 5'h1F, 8'h00, 8'hFF},
                            '{8'hD9, 5'h0A, 8'hFF, 8'hEA}, '{8'hD8, 5'h1F, 8'hA5, 8'hA5},
                            '{8'hD8, 5'h00, 8'h5A, 8'h5A}, '{8'hDC, 5'h1F, 8'hFF, 8'h00}};

   always #10 ref_clk_i = ~ref_clk_i;

   cpu_can_sfr_port cpu_can_sfr_port_i (.*);
   can_core_model can_core_model_i (.ref_clk_i(ref_clk_i), .reg_addr_i(can_reg_addr_o), .reg_wr_i(can_reg_wr_o),
      .reg_wdata_i(can_reg_wdata_o), .reg_rdata_o(can_reg_rdata_i), .cmd_wr_i(can_cmd_wr_o), .cmd_i(can_cmd_o),
      .dma_start_i(dma_start_o), .dma_ram_addr_i(dma_ram_addr_o), .dma_buf_addr_i(dma_buf_addr_o),
      .ok_mode_i(ok_mode), .dma_done_o(dma_done_i), .dma_ok_o(dma_ok_i));

   // ------------------------------------------------------------
   // tasks
   // ------------------------------------------------------------
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic sfr(input logic wr, input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk_i);
      sfr_addr_i  <= a;
      sfr_wdata_i <= d;
      sfr_rd_i    <= !wr;
      sfr_wr_i    <= wr;
      @(posedge ref_clk_i);
      sfr_rd_i <= 1'b0;
      sfr_wr_i <= 1'b0;
      #1 q = sfr_rvalid_o ? sfr_rdata_o : 8'hXX;
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
      sfr(1'b0, a, 8'h00);
      check(q, exp);
   endtask
   task automatic bit_acc(input logic wr, input logic [2:0] n, input logic v);
      @(posedge ref_clk_i);
      bit_addr_i  <= can_sfr_pkg::STATUS_BIT_ADDR_LO + n;
      bit_wdata_i <= v;
      bit_rd_i    <= !wr;
      bit_wr_i    <= wr;
      @(posedge ref_clk_i);
      bit_rd_i <= 1'b0;
      bit_wr_i <= 1'b0;
      #1 b = bit_rvalid_o ? bit_rdata_o : 1'bx;
   endtask
   task automatic settle;
      @(posedge ref_clk_i);
      #1;
   endtask
   // busy output lags the launch, so give it time to rise first
   task automatic wait_idle;
      int n;
      n = 0;
      repeat (3) @(posedge ref_clk_i);
      do begin
         settle();
         n++;
      end while (dma_busy_o !== 1'b0 && n < 50);
      if (n >= 50) mismatches++;
   endtask
   task automatic end_sim;
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   // ------------------------------------------------------------
   // sequence
   // ------------------------------------------------------------
   initial begin
      repeat (6) @(posedge ref_clk_i);
      reset_n_i <= 1'b1;
      repeat (3) settle();
      check({3'h0, can_reg_addr_o}, 8'h04);
      rd_chk(8'hDB, 8'h64);
      foreach (rows[i]) begin
         @(posedge ref_clk_i);
         can_irq_i    <= rows[i].irq;
         can_status_i <= rows[i].stat;
         rd_chk(rows[i].addr, rows[i].exp);
      end
      for (int i = 0; i < 3; i++) sfr(1'b1, 8'hDA, 8'(8'hA0 + i));
      settle();
      for (int i = 0; i < 3; i++) check(can_core_model_i.mem[4 + i], 8'(8'hA0 + i));
      rd_chk(8'hDB, 8'h67);
      sfr(1'b1, 8'hDB, 8'h48);
      sfr(1'b1, 8'hDA, 8'h5C);
      rd_chk(8'hDA, 8'h5C);
      rd_chk(8'hDA, 8'h5C);
      rd_chk(8'hDB, 8'h48);
      check(can_core_model_i.mem[8], 8'h5C);
      sfr(1'b1, 8'hDB, 8'h3F);
      sfr(1'b1, 8'hDA, 8'h3C);
      rd_chk(8'hDB, 8'h00);
      check(can_core_model_i.mem[31], 8'h3C);
      // commands are written outright, never read back and modified
      for (int i = 0; i < 8; i++) begin
         sfr(1'b1, 8'hD9, 8'(1 << i));
         settle();
         check(can_core_model_i.last_cmd, 8'(1 << i));
      end
      sfr(1'b1, 8'hD8, 8'hC3);
      @(posedge ref_clk_i);
      can_status_i <= 8'h96;
      for (int n = 0; n < 8; n++) begin
         bit_acc(1'b0, 3'(n), 1'b0);
         check({7'h00, b}, {7'h00, can_status_i[n]});
      end
      rd_chk(8'hD8, 8'h96);
      bit_acc(1'b1, 3'd0, 1'b0);
      bit_acc(1'b1, 3'd7, 1'b0);
      @(posedge ref_clk_i);
      ok_mode <= 1'b1;
      sfr(1'b1, 8'hDB, 8'h8A);
      sfr(1'b1, 8'hDA, 8'hEE);
      wait_idle();
      check(8'(can_core_model_i.starts), 8'h01);
      check(can_core_model_i.ram_seen, 8'h42);
      check({3'h0, can_core_model_i.buf_seen}, 8'h0A);
      check(can_core_model_i.mem[10], 8'h00);
      rd_chk(8'hDB, 8'h0A);
      @(posedge ref_clk_i);
      ok_mode <= 1'b0;
      sfr(1'b1, 8'hDB, 8'h94);
      wait_idle();
      rd_chk(8'hDB, 8'h94);
      @(posedge ref_clk_i);
      can_reset_request_i <= 1'b1;
      sfr(1'b1, 8'hDB, 8'h8A);
      repeat (3) settle();
      rd_chk(8'hDB, 8'h0A);
      check(8'(can_core_model_i.starts), 8'h02);
      // second reset in mid-run brings the index back
      @(posedge ref_clk_i);
      reset_n_i           <= 1'b0;
      can_reset_request_i <= 1'b0;
      repeat (6) @(posedge ref_clk_i);
      reset_n_i <= 1'b1;
      repeat (3) settle();
      check({3'h0, can_reg_addr_o}, 8'h04);
      check({7'h00, auto_index_bump_o}, 8'h01);
      rd_chk(8'hDB, 8'h64);
      end_sim();
   end

   initial begin
      #200000;
      mismatches++;
      end_sim();
   end
endmodule // cpu_can_sfr_port_tb
